// ### adcfs_map.svh
`ifndef ADCFS_MAP_SVH
`define ADCFS_MAP_SVH

// Register byte addresses
`define ADCFS_OFF_CTRL1     8'h00
`define ADCFS_OFF_CHSEL0    8'h04
`define ADCFS_OFF_IRQ_STAT  8'h08
`define ADCFS_OFF_IRQ_MASK  8'h0C
`define ADCFS_OFF_RESULT    8'h10
`define ADCFS_OFF_DMA_CFG   8'h14
`define ADCFS_OFF_DMA_ADDR  8'h18
`define ADCFS_OFF_STATUS    8'h1C

// Control register one field positions
`define ADCFS_BIT_ON        15
`define ADCFS_BIT_SIDL      13
`define ADCFS_BIT_DMABM     12
`define ADCFS_BIT_RES12     10
`define ADCFS_BIT_RESULT_FORMAT_CODE_HI   9
`define ADCFS_BIT_RESULT_FORMAT_CODE_LO   8
`define ADCFS_BIT_AUTO_SAMPLE_ENABLE      2
`define ADCFS_BIT_SAMPLE_ACTIVE      1
`define ADCFS_BIT_DONE      0

// Writable mask of control register one
`define ADCFS_CTRL1_WMASK   16'hB7FE
`define ADCFS_CTRL1_RESET   16'h0000
`define ADCFS_CHSEL_RESET   5'h00

// Timing counts in aclk cycles
`define ADCFS_SAMPLE_CYC    8'h10
`define ADCFS_CONV10_CYC    8'h0C
`define ADCFS_CONV12_CYC    8'h0E

// Interrupt status bits
`define ADCFS_IRQ_DONE      0
`define ADCFS_IRQ_OVR       1

`endif

// ### adcfs_pkg.sv
package adcfs_pkg;

    typedef enum logic [1:0] {
        ADCFS_FMT_INT,
        ADCFS_FMT_SINT,
        ADCFS_FMT_FRAC,
        ADCFS_FMT_SFRAC
    } adcfs_fmt_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
        logic [15:0] addr;
    } adcfs_dma_t;

    typedef struct packed {
        logic       open;
        logic       temp_diode;
        logic       amp_out;
        logic [1:0] amp_idx;
        logic       pin_valid;
        logic [3:0] pin_idx;
    } adcfs_route_t;

endpackage

// ### adcfs_top.sv
// What this block does
// - Converter runs only while converter_on is one; otherwise it is held off.
// - With idle-stop set, conversions halt while the device is idle.
// - Build-mode one: DMA address is the stand-alone buffer address, in order.
// - Build-mode zero: DMA address from input index and DMA buffer size.
// - Resolution select one gives 12-bit single channel, zero 10-bit four channel.
// - Format 00: right-justified raw result, upper bits zero.
// - Format 01: right-justified, upper bits are inverted result MSB.
// - Format 10: left-justified raw result, low bits zero.
// - Format 11: left-justified, top bit inverted MSB, low bits zero.
// - Hardware sets and clears sample and only sets done; software writes sample, clears done.
// - Select codes 0 to 15 route analog inputs 0 to 15.
// - Codes 11000, 11001, 11010 route amplifiers one, two, three.
// - Code 11110 routes the temperature diode of the charge-time unit.
// - Code 11111 leaves the sampler input open.
// - Amplifier output routed only when its mode bit is set, else shared pin.
// - Comparator or amplifier use reassigns inputs 0 to 7 for channels 1 to 3.
`timescale 1ns/1ps
`default_nettype none
`include "adcfs_map.svh"

module adcfs_top (
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // AXI4-Lite write address and data
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    // AXI4-Lite write response
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    output logic [1:0]                 s_axi_bresp,
    // AXI4-Lite read
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    input  wire logic [7:0]            s_axi_araddr,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    // Device state and amplifier modes
    input  wire logic                  device_idle,
    input  wire logic [2:0]            amplifier_mode_select,
    input  wire logic                  comparator_enable,
    // Converter core
    input  wire logic [11:0]           core_raw_result,
    output logic                       core_enable,
    output logic                       core_sample,
    output logic                       core_convert,
    output logic                       core_res12,
    output adcfs_pkg::adcfs_route_t    core_route,
    output logic                       core_inputs_reassigned,
    // DMA channel
    output adcfs_pkg::adcfs_dma_t      dma_out,
    // Interrupt
    output logic                       irq
);
    import adcfs_pkg::*;

    typedef enum logic [1:0] {
        ADCFS_IDLE,
        ADCFS_SAMPLE,
        ADCFS_CONVERT
    } adcfs_state_t;

    function automatic logic [15:0] adcfs_format(input logic [11:0] raw, input logic res12,
                                                 input logic [1:0] code);
        logic [15:0] w;
        w = 16'h0000;
        case (code)
            2'b00: w = res12 ? {4'h0, raw} : {6'h00, raw[9:0]};
            2'b01: w = res12 ? {{5{~raw[11]}}, raw[10:0]} : {{7{~raw[9]}}, raw[8:0]};
            2'b10: w = res12 ? {raw, 4'h0} : {raw[9:0], 6'h00};
            2'b11: w = res12 ? {~raw[11], raw[10:0], 4'h0} : {~raw[9], raw[8:0], 6'h00};
            default: w = 16'h0000;
        endcase
        return w;
    endfunction

    function automatic logic wsel(input logic [7:0] a, input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction

    // Register state
    logic [15:0]  ctrl1_q;
    logic [4:0]   chsel_q;
    logic [1:0]   irq_stat_q;
    logic [1:0]   irq_mask_q;
    logic [15:0]  result_q;
    logic [15:0]  dma_addr_q;
    logic [3:0]   dma_size_q;
    logic [15:0]  dma_base_q;
    logic [15:0]  seq_q;
    logic [7:0]   cnt_q;
    adcfs_state_t state_q;
    logic         idle_s1_q;
    logic         idle_s2_q;

    // Bus holding registers
    logic         aw_have_q;
    logic         w_have_q;
    logic [7:0]   aw_addr_q;
    logic [31:0]  w_data_q;
    logic [3:0]   w_strb_q;

    // Write decode
    wire          wr_fire    = aw_have_q && w_have_q && !s_axi_bvalid;
    wire          wr_lo      = w_strb_q[0];
    wire          wr_hi      = w_strb_q[1];
    wire          wr_ctrl1   = wr_fire && wsel(aw_addr_q, `ADCFS_OFF_CTRL1);
    wire          wr_chsel   = wr_fire && wsel(aw_addr_q, `ADCFS_OFF_CHSEL0) && wr_lo;
    wire          wr_stat    = wr_fire && wsel(aw_addr_q, `ADCFS_OFF_IRQ_STAT) && wr_lo;
    wire          wr_mask    = wr_fire && wsel(aw_addr_q, `ADCFS_OFF_IRQ_MASK) && wr_lo;
    wire          wr_dmacfg  = wr_fire && wsel(aw_addr_q, `ADCFS_OFF_DMA_CFG);
    wire          wr_mapped  = aw_addr_q[7:5] == 3'b000;

    // Control fields
    wire          on_b       = ctrl1_q[`ADCFS_BIT_ON];
    wire          sidl_b     = ctrl1_q[`ADCFS_BIT_SIDL];
    wire          dmabm_b    = ctrl1_q[`ADCFS_BIT_DMABM];
    wire          res12_b    = ctrl1_q[`ADCFS_BIT_RES12];
    wire [1:0]    result_format_code_b     = ctrl1_q[`ADCFS_BIT_RESULT_FORMAT_CODE_HI:`ADCFS_BIT_RESULT_FORMAT_CODE_LO];
    wire          auto_sample_enable_b     = ctrl1_q[`ADCFS_BIT_AUTO_SAMPLE_ENABLE];
    wire          sample_active_b     = ctrl1_q[`ADCFS_BIT_SAMPLE_ACTIVE];
    wire          done_b     = ctrl1_q[`ADCFS_BIT_DONE];

    wire          run        = on_b && !(sidl_b && idle_s2_q);
    wire [7:0]    conv_len   = res12_b ? `ADCFS_CONV12_CYC : `ADCFS_CONV10_CYC;
    wire          cnt_end    = cnt_q == 8'h00;
    wire          sample_active_end   = state_q == ADCFS_SAMPLE && cnt_end && run;
    wire          conv_end   = state_q == ADCFS_CONVERT && cnt_end && run;
    wire [15:0]   fmt_word   = adcfs_format(core_raw_result, res12_b, result_format_code_b);

    wire [15:0]   sg_addr    = dma_base_q
                               + 16'(({12'h000, chsel_q[3:0]} << dma_size_q) << 1);
    wire [15:0]   ord_addr   = dma_base_q + 16'({seq_q[14:0], 1'b0});
    wire [15:0]   next_addr  = dmabm_b ? ord_addr : sg_addr;

    wire          sel_pin    = chsel_q[4] == 1'b0;
    wire          sel_amp    = chsel_q[4:3] == 2'b11 && chsel_q[2:0] <= 3'd2;
    wire [1:0]    amp_i      = chsel_q[1:0];
    wire          amp_on     = sel_amp && amplifier_mode_select[amp_i];
    wire [3:0]    amp_pin    = amp_i == 2'd0 ? 4'd3 : (amp_i == 2'd1 ? 4'd0 : 4'd6);
    adcfs_route_t route_d;
    assign route_d.open       = chsel_q == 5'b11111;
    assign route_d.temp_diode = chsel_q == 5'b11110;
    assign route_d.amp_out    = amp_on;
    assign route_d.amp_idx    = sel_amp ? amp_i : 2'd0;
    assign route_d.pin_valid  = sel_pin || (sel_amp && !amp_on);
    assign route_d.pin_idx    = sel_pin ? chsel_q[3:0] : (sel_amp ? amp_pin : 4'd0);

    // Read mux
    wire [7:0]    ra         = s_axi_araddr;
    wire          rd_ok      = ra[7:5] == 3'b000;
    wire [31:0]   rd_word    = wsel(ra, `ADCFS_OFF_CTRL1)    ? {16'h0000, ctrl1_q}
                   : wsel(ra, `ADCFS_OFF_CHSEL0)   ? {27'h0, chsel_q}
                   : wsel(ra, `ADCFS_OFF_IRQ_STAT) ? {30'h0, irq_stat_q}
                   : wsel(ra, `ADCFS_OFF_IRQ_MASK) ? {30'h0, irq_mask_q}
                   : wsel(ra, `ADCFS_OFF_RESULT)   ? {16'h0000, result_q}
                   : wsel(ra, `ADCFS_OFF_DMA_CFG)  ? {dma_base_q, 12'h000, dma_size_q}
                   : wsel(ra, `ADCFS_OFF_DMA_ADDR) ? {16'h0000, dma_addr_q}
                   : {24'h0, 4'h0, res12_b, run, state_q};

    // Idle input synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idle_s1_q <= 1'b0;
            idle_s2_q <= 1'b0;
        end else begin
            idle_s1_q <= device_idle;
            idle_s2_q <= idle_s1_q;
        end
    end

    // AXI write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
        end else begin
            s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_ok ? rd_word : 32'h0000_0000;
                s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Control register one
    logic [15:0] ctrl1_d;
    always_comb begin
        ctrl1_d = ctrl1_q;
        if (wr_ctrl1) begin
            if (wr_lo)
                ctrl1_d[7:1] = w_data_q[7:1];
            if (wr_hi)
                ctrl1_d[15:8] = w_data_q[15:8] & 8'(`ADCFS_CTRL1_WMASK >> 8);
            if (wr_lo && !w_data_q[`ADCFS_BIT_DONE])
                ctrl1_d[`ADCFS_BIT_DONE] = 1'b0;
        end
        if (sample_active_end)
            ctrl1_d[`ADCFS_BIT_SAMPLE_ACTIVE] = 1'b0;
        if (conv_end) begin
            ctrl1_d[`ADCFS_BIT_DONE] = 1'b1;
            ctrl1_d[`ADCFS_BIT_SAMPLE_ACTIVE] = auto_sample_enable_b;
        end
        if (state_q == ADCFS_IDLE && run && auto_sample_enable_b)
            ctrl1_d[`ADCFS_BIT_SAMPLE_ACTIVE] = 1'b1;
        ctrl1_d = ctrl1_d & `ADCFS_CTRL1_WMASK | {15'h0, ctrl1_d[`ADCFS_BIT_DONE]};
    end

    // Sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl1_q <= `ADCFS_CTRL1_RESET;
            state_q <= ADCFS_IDLE;
            cnt_q   <= 8'h00;
        end else begin
            ctrl1_q <= ctrl1_d;
            if (!on_b) begin
                state_q <= ADCFS_IDLE;
            end else if (run) begin
                case (state_q)
                    ADCFS_IDLE: if (sample_active_b || auto_sample_enable_b) begin
                        state_q <= ADCFS_SAMPLE;
                        cnt_q   <= `ADCFS_SAMPLE_CYC;
                    end
                    ADCFS_SAMPLE: if (cnt_end) begin
                        state_q <= ADCFS_CONVERT;
                        cnt_q   <= conv_len;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                    ADCFS_CONVERT: if (cnt_end) begin
                        state_q <= ADCFS_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                    default: state_q <= ADCFS_IDLE;
                endcase
            end
        end
    end

    // Result, DMA and other registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chsel_q    <= `ADCFS_CHSEL_RESET;
            result_q   <= 16'h0000;
            dma_addr_q <= 16'h0000;
            dma_size_q <= 4'h0;
            dma_base_q <= 16'h0000;
            seq_q      <= 16'h0000;
            irq_stat_q <= 2'b00;
            irq_mask_q <= 2'b00;
            dma_out    <= '0;
            irq        <= 1'b0;
        end else begin
            if (wr_chsel)
                chsel_q <= w_data_q[4:0];
            if (wr_mask)
                irq_mask_q <= w_data_q[1:0];
            if (wr_dmacfg) begin
                dma_size_q <= w_data_q[3:0];
                dma_base_q <= w_data_q[31:16];
                seq_q      <= 16'h0000;
            end
            dma_out.valid <= 1'b0;
            if (conv_end) begin
                result_q      <= fmt_word;
                dma_addr_q    <= next_addr;
                dma_out.valid <= 1'b1;
                dma_out.data  <= fmt_word;
                dma_out.addr  <= next_addr;
                seq_q         <= seq_q + 16'h0001;
            end
            // Set wins over write-one clear
            irq_stat_q <= (irq_stat_q & ~(wr_stat ? w_data_q[1:0] : 2'b00))
                          | {conv_end && done_b, conv_end};
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Core drive
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_enable            <= 1'b0;
            core_sample            <= 1'b0;
            core_convert           <= 1'b0;
            core_res12             <= 1'b0;
            core_route             <= '0;
            core_inputs_reassigned <= 1'b0;
        end else begin
            core_enable            <= run;
            core_sample            <= run && state_q == ADCFS_SAMPLE;
            core_convert           <= run && state_q == ADCFS_CONVERT;
            core_res12             <= res12_b;
            core_route             <= route_d;
            core_inputs_reassigned <= comparator_enable || (|amplifier_mode_select);
        end
    end

endmodule

`default_nettype wire

// ### adcfs_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module adcfs_checker (
    // Clock and reset
    input wire logic                    aclk,
    input wire logic                    aresetn,
    // Bus handshake
    input wire logic                    s_axi_awready,
    input wire logic                    s_axi_rvalid,
    input wire logic                    s_axi_rready,
    // Amplifier and comparator controls
    input wire logic [2:0]              amplifier_mode_select,
    input wire logic                    comparator_enable,
    // Converter side
    input wire logic                    core_enable,
    input wire logic                    core_sample,
    input wire logic                    core_convert,
    input wire adcfs_pkg::adcfs_route_t core_route,
    input wire logic                    core_inputs_reassigned,
    input wire adcfs_pkg::adcfs_dma_t   dma_out,
    input wire logic                    irq
);
    import adcfs_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_quiet;
        !core_enable && !irq && !dma_out.valid;
    endsequence
    sequence s_conv_hold;
        core_convert [*8];
    endsequence

    property p_rst_clear;
        $rose(aresetn) |-> s_quiet;
    endproperty
    property p_dma_pulse;
        dma_out.valid |=> !dma_out.valid;
    endproperty
    property p_active_on;
        (core_sample || core_convert) |-> core_enable;
    endproperty
    property p_one_phase;
        !(core_sample && core_convert);
    endproperty
    property p_conv_len;
        $rose(core_convert) |-> s_conv_hold;
    endproperty
    property p_aw_pulse;
        s_axi_awready |=> !s_axi_awready;
    endproperty
    property p_r_single;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    property p_reassign;
        $past(aresetn) |->
            core_inputs_reassigned == $past(comparator_enable || (|amplifier_mode_select));
    endproperty
    property p_amp_gate;
        core_route.amp_out |-> |($past(amplifier_mode_select) & (3'b001 << core_route.amp_idx));
    endproperty
    property p_route_one;
        $onehot0({core_route.open, core_route.temp_diode, core_route.amp_out,
                  core_route.pin_valid});
    endproperty

    a_rst_clear: assert property (p_rst_clear) else $error("outputs busy after reset");
    a_dma_pulse: assert property (p_dma_pulse) else $error("dma valid too long");
    a_active_on: assert property (p_active_on) else $error("core active while off");
    a_one_phase: assert property (p_one_phase) else $error("sample and convert overlap");
    a_conv_len: assert property (p_conv_len) else $error("conversion too short");
    a_aw_pulse: assert property (p_aw_pulse) else $error("awready not a pulse");
    a_r_single: assert property (p_r_single) else $error("second read data beat");
    a_reassign: assert property (p_reassign) else $error("reassign flag wrong");
    a_amp_gate: assert property (p_amp_gate) else $error("amplifier routed unmoded");
    a_route_one: assert property (p_route_one) else $error("several routes at once");
endmodule

bind adcfs_top adcfs_checker u_adcfs_checker (
    .aclk, .aresetn, .s_axi_awready, .s_axi_rvalid, .s_axi_rready,
    .amplifier_mode_select, .comparator_enable, .core_enable, .core_sample,
    .core_convert, .core_route, .core_inputs_reassigned, .dma_out, .irq
);
`default_nettype wire

// ### adcfs_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcfs_core_model (
    // Clock and converter handshake
    input wire logic         aclk,
    input wire logic         core_sample,
    input wire logic         core_res12,
    // Level to be converted
    input wire logic [11:0]  analog_level,
    // Result towards the block
    output logic [11:0]      core_raw_result
);
    logic [11:0] junk_q = 12'h5A5;

    // Result lines churn while sampling
    always @(posedge aclk) junk_q <= ~junk_q + 12'h3C7;

    assign core_raw_result = core_sample ? junk_q :
                             (core_res12 ? analog_level : {2'b00, analog_level[9:0]});
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcfs_map.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    import adcfs_pkg::*;
    logic               aclk = 0;
    logic               aresetn = 0;
    logic               s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic               s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0]         s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0]        s_axi_wdata = 0;
    logic               device_idle = 0, comparator_enable = 0;
    logic [2:0]         amplifier_mode_select = 0;
    logic [11:0]        analog_level = 0, core_raw_result;
    logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]         s_axi_bresp, s_axi_rresp;
    logic [31:0]        s_axi_rdata;
    logic               core_enable, core_sample, core_convert, core_res12, core_reas, irq;
    adcfs_route_t       core_route;
    adcfs_dma_t         dma_out;
    int                 err_count = 0, n_checks = 0;
    int                 seed = 32'h0000_7C2C;
    logic [33:0]        rq_e[$], rq_m[$], we, wm;
    logic [31:0]        dq_e[$], dq_m[$], de, dm;
    logic [7:0]         rt;

    always #2.5 aclk = ~aclk;

    adcfs_top u_adcfs_top (
        .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .device_idle, .amplifier_mode_select,
        .comparator_enable, .core_raw_result, .core_enable, .core_sample, .core_convert,
        .core_res12, .core_route, .core_inputs_reassigned(core_reas), .dma_out, .irq
    );
    adcfs_core_model u_adcfs_core_model (
        .aclk, .core_sample, .core_res12, .analog_level, .core_raw_result
    );

    task automatic complete_run();
        $display("TB: errors=%0d checks=%0d", err_count, n_checks);
        if (err_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic give_up(input int k);
        if (k >= 400) begin
            err_count++;
            complete_run();
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            k++;
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid && k < 400);
        give_up(k);
        `CHK(s_axi_bresp, {a[7:5] != 3'b000, 1'b0})
        s_axi_bready <= 0;
        @(posedge aclk);
    endtask

    task automatic axr(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m);
        int k;
        k = 0;
        rq_e.push_back(e);
        rq_m.push_back(m);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            k++;
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid && k < 400);
        give_up(k);
        s_axi_rready <= 0;
        @(posedge aclk);
    endtask

    task automatic waitq();
        int k;
        k = 0;
        while (dq_e.size() != 0 && k < 400) begin
            @(posedge aclk);
            k++;
        end
        give_up(k);
    endtask

    // Stop the converter with done kept, then clear done with a second write
    task automatic stop();
        axw(`ADCFS_OFF_CTRL1, 32'h0000_0001);
        axw(`ADCFS_OFF_CTRL1, 32'h0000_0000);
    endtask

    function automatic logic [15:0] fmt(logic [11:0] r, logic b12, logic [1:0] f);
        logic s;
        s = b12 ? ~r[11] : ~r[9];
        case ({b12, f})
            3'b000: fmt = {6'h00, r[9:0]};
            3'b001: fmt = {{7{s}}, r[8:0]};
            3'b010: fmt = {r[9:0], 6'h00};
            3'b011: fmt = {s, r[8:0], 6'h00};
            3'b100: fmt = {4'h0, r};
            3'b101: fmt = {{5{s}}, r[10:0]};
            3'b110: fmt = {r, 4'h0};
            default: fmt = {s, r[10:0], 4'h0};
        endcase
    endfunction

    function automatic logic [7:0] rexp(logic [4:0] c, logic [2:0] m);
        logic [3:0] sh;
        sh = (c == 5'h18) ? 4'h3 : ((c == 5'h19) ? 4'h0 : 4'h6);
        if (!c[4]) rexp = {4'h1, c[3:0]};
        else if (c >= 5'h18 && c <= 5'h1A) rexp = m[c[1:0]] ? 8'h20 : {4'h1, sh};
        else if (c == 5'h1E) rexp = 8'h40;
        else if (c == 5'h1F) rexp = 8'h80;
        else rexp = 8'h00;
    endfunction

    task automatic conv(input logic [2:0] i);
        logic [11:0] r;
        logic [15:0] c, d;
        r = 12'($random(seed));
        d = fmt(r, i[2], i[1:0]);
        dq_e.push_back({i[2] ? 16'h4028 : 16'h4000, d});
        dq_m.push_back((i == 3'h0 || i[2]) ? 32'hFFFF_FFFF : 32'h0000_FFFF);
        analog_level <= r;
        device_idle <= i[0];
        c = 16'h80E4 | {3'b000, !i[2], 1'b0, i[2], i[1:0], 8'h00};
        axw(`ADCFS_OFF_IRQ_MASK, {31'h0, i != 3'h7});
        axw(`ADCFS_OFF_CTRL1, {16'h0000, c});
        waitq();
        `CHK({core_enable, core_res12}, {1'b1, i[2]})
        axw(`ADCFS_OFF_CTRL1, {16'h0000, (c & 16'h7FF8) | 16'h0001});
        axr(`ADCFS_OFF_CTRL1, 34'h1, 34'h1);
        `CHK(irq, i != 3'h7)
        axr(`ADCFS_OFF_RESULT, {18'h0, d}, 34'h3_FFFF_FFFF);
        axw(`ADCFS_OFF_IRQ_STAT, 32'h0000_0003);
        axw(`ADCFS_OFF_CTRL1, 32'h0000_0000);
        axr(`ADCFS_OFF_CTRL1, 34'h0, 34'h3_FFFF_FFFF);
        `CHK(irq, 1'b0)
    endtask

    always @(posedge aclk) begin
        if (aresetn && s_axi_rvalid && s_axi_rready) begin
            we = rq_e.pop_front();
            wm = rq_m.pop_front();
            `CHK({s_axi_rresp, s_axi_rdata} & wm, we & wm)
        end
        if (aresetn && dma_out.valid && dq_e.size() == 0) `CHK(1'b1, 1'b0)
        else if (aresetn && dma_out.valid) begin
            de = dq_e.pop_front();
            dm = dq_m.pop_front();
            `CHK({dma_out.addr, dma_out.data} & dm, de & dm)
        end
    end

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        axr(`ADCFS_OFF_CTRL1, 34'h0, 34'h3_FFFF_FFFF);
        axr(`ADCFS_OFF_CHSEL0, 34'h0, 34'h3_FFFF_FFFF);
        axw(`ADCFS_OFF_CTRL1, 32'hFFFF_77FC);
        axr(`ADCFS_OFF_CTRL1, 34'h0_0000_37FC, 34'h3_FFFF_FFFC);
        stop();
        axr(8'h20, 34'h2_0000_0000, 34'h3_FFFF_FFFF);
        axw(8'h20, 32'h0000_0000);
        axw(`ADCFS_OFF_DMA_CFG, 32'h4000_0002);
        axw(`ADCFS_OFF_CHSEL0, 32'h0000_0005);
        for (int i = 0; i < 8; i++) conv(3'(i));
        device_idle <= 1;
        analog_level <= 12'h2A5;
        axw(`ADCFS_OFF_CTRL1, 32'h0000_A0E4);
        repeat (200) @(posedge aclk);
        `CHK({core_enable, core_sample, core_convert}, 3'b000)
        dq_e.push_back({16'h4028, 16'h02A5});
        dq_m.push_back(32'hFFFF_FFFF);
        device_idle <= 0;
        waitq();
        stop();
        for (int c = 0; c < 32; c++) begin
            amplifier_mode_select <= 3'($random(seed));
            comparator_enable <= 1'($random(seed));
            axw(`ADCFS_OFF_CHSEL0, {27'h0, 5'(c)});
            repeat (2) @(posedge aclk);
            rt = {core_route.open, core_route.temp_diode, core_route.amp_out,
                  core_route.pin_valid, core_route.pin_valid ? core_route.pin_idx : 4'h0};
            `CHK(rt, rexp(5'(c), amplifier_mode_select))
            `CHK(core_reas, comparator_enable | (|amplifier_mode_select))
        end
        complete_run();
    end
endmodule
`default_nettype wire
